// >>> dmbia_top.sv
// Purpose: Data memory decoder, pointers, bank selector and accumulator
// Assumes: One access per cycle from the core execution logic
// Notes: Peripheral registers live elsewhere; their reads enter on periph_rdata_i
`include "dmbia_defines.svh"
module dmbia_top (
   input wire logic sys_clk_i, // System clock
   input wire logic rst_i, // Reset, active high; asynchronous except for the bank selector, which samples it on the clock
   input wire logic wdt_pd_rst_i, // Reset is watchdog time-out in power-down
   input wire logic [7:0] addr_i, // Operand address
   input wire logic rd_i, // Read strobe
   input wire logic wr_i, // Write strobe
   input wire logic [7:0] wdata_i, // Write data from core
   input wire logic acc_load_i, // Load accumulator
   input wire logic [1:0] acc_src_i, // Accumulator source select
   input wire logic [7:0] alu_result_i, // ALU result
   input wire logic [7:0] periph_rdata_i, // Peripheral register read data
   input wire logic periph_hit_i, // Peripheral claims the address
   output logic [7:0] rdata_o, // Read data
   output logic periph_wr_o, // Write forwarded to a peripheral
   output logic periph_rd_o, // Read forwarded to a peripheral
   output logic [7:0] periph_addr_o, // Special area address for peripherals
   output logic [7:0] acc_o, // Accumulator
   output logic [7:0] ptr0_o, // Pointer zero
   output logic [7:0] ptr1_o, // Pointer one
   output logic [7:0] bank_o // Bank selector
);
   dmbia_pkg::dmbia_byte_t ptr0_q, ptr1_q, bank_q, acc_q;
   logic [7:0] eff_addr, eff_bank, ram_rdata;
   logic indirect, null_acc, sfr, absent;
   logic wr_ok, sel_ptr0, sel_ptr1, sel_bank, sel_acc, ram_we;
   logic [7:0] rd_d;
   logic sel_local;

   dmbia_addr_map u_map (
      .addr_i(addr_i),
      .ptr0_i(ptr0_q),
      .ptr1_i(ptr1_q),
      .bank_i(bank_q),
      .eff_addr_o(eff_addr),
      .eff_bank_o(eff_bank),
      .indirect_o(indirect),
      .null_o(null_acc),
      .sfr_o(sfr),
      .absent_o(absent)
   );

   assign wr_ok = wr_i && !null_acc;
   assign sel_ptr0 = sfr && (eff_addr == `DMBIA_ADDR_PTR0);
   assign sel_ptr1 = sfr && (eff_addr == `DMBIA_ADDR_PTR1);
   assign sel_bank = sfr && (eff_addr == `DMBIA_ADDR_BANK);
   assign sel_acc = sfr && (eff_addr == `DMBIA_ADDR_ACC);
   assign sel_local = sel_ptr0 || sel_ptr1 || sel_bank || sel_acc;
   assign ram_we = wr_ok && !sfr && !absent;
   assign periph_addr_o = eff_addr;
   assign periph_wr_o = wr_ok && sfr && !sel_local;
   assign periph_rd_o = rd_i && !null_acc && sfr && !sel_local;

   dmbia_ram u_ram (
      .sys_clk_i(sys_clk_i),
      .we_i(ram_we),
      .addr_i({eff_bank[3:0], eff_addr}),
      .wdata_i(wdata_i),
      .rdata_o(ram_rdata)
   );

   // Pointers behave as plain storage
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr0_q <= `DMBIA_RST_REG;
      end else if (wr_ok && sel_ptr0) begin
         ptr0_q <= wdata_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ptr1_q <= `DMBIA_RST_REG;
      end else if (wr_ok && sel_ptr1) begin
         ptr1_q <= wdata_i;
      end
   end

   // Watchdog reset in power-down keeps the bank: a clocked capture holds it
   logic bank_keep_q;
   always_ff @(posedge sys_clk_i) begin
      bank_keep_q <= wdt_pd_rst_i;
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i && !bank_keep_q && !wdt_pd_rst_i) begin
         bank_q <= `DMBIA_RST_BANK;
      end else if (!rst_i && wr_ok && sel_bank) begin
         bank_q <= wdata_i;
      end
   end

   // Accumulator takes ALU results or a data move; no memory-to-memory path exists
   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_q <= `DMBIA_RST_REG;
      end else if (acc_load_i) begin
         case (dmbia_pkg::dmbia_accsrc_e'(acc_src_i))
            dmbia_pkg::DMBIA_SRC_ALU: acc_q <= alu_result_i;
            dmbia_pkg::DMBIA_SRC_MEM: acc_q <= rd_d;
            default: acc_q <= wdata_i;
         endcase
      end else if (wr_ok && sel_acc) begin
         acc_q <= wdata_i;
      end
   end

   always_comb begin
      rd_d = 8'h00;
      if (null_acc || absent) begin
         rd_d = 8'h00;
      end else if (sel_ptr0) begin
         rd_d = ptr0_q;
      end else if (sel_ptr1) begin
         rd_d = ptr1_q;
      end else if (sel_bank) begin
         rd_d = bank_q;
      end else if (sel_acc) begin
         rd_d = acc_q;
      end else if (sfr) begin
         rd_d = periph_hit_i ? periph_rdata_i : 8'h00;
      end else begin
         rd_d = ram_rdata;
      end
   end

   always_ff @(posedge sys_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         rdata_o <= rd_d;
      end
   end

   assign acc_o = acc_q;
   assign ptr0_o = ptr0_q;
   assign ptr1_o = ptr1_q;
   assign bank_o = bank_q;

   a_null_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && null_acc) |=> (rdata_o == 8'h00))
      else $error("read through port aimed at port not zero");

   a_direct_bank0: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!indirect) |-> (eff_bank == 8'h00))
      else $error("direct access left bank 0");

   a_ptr_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == `DMBIA_ADDR_PTR1) |=> (ptr1_q == $past(wdata_i)))
      else $error("pointer one write lost");

   a_bank_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !(wr_ok && sel_bank) |=> $stable(bank_q))
      else $error("bank selector changed without write");

   a_null_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && null_acc) |-> !(ram_we || periph_wr_o))
      else $error("write through port aimed at port took effect");

   a_port0_bank: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (addr_i == `DMBIA_ADDR_IND0) |-> (eff_bank == 8'h00 && eff_addr == ptr0_q))
      else $error("port zero left bank 0");

   a_alu_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (acc_load_i && acc_src_i == 2'b01) |=> (acc_o == $past(alu_result_i)))
      else $error("accumulator missed ALU result");

   a_unused_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && sfr && !periph_hit_i && !null_acc && eff_addr > `DMBIA_ADDR_ACC) |=> (rdata_o == 8'h00))
      else $error("unused location not zero");

   // Routing, storage and reset checks
   a_ptr0_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == `DMBIA_ADDR_PTR0)
      |=> (ptr0_q == $past(wdata_i)))
      else $error("pointer zero write lost");

   a_ptr0_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !(wr_ok && sel_ptr0)
      |=> $stable(ptr0_q))
      else $error("pointer zero changed without write");

   a_ptr1_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !(wr_ok && sel_ptr1)
      |=> $stable(ptr1_q))
      else $error("pointer one changed without write");

   a_ptr0_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && sel_ptr0)
      |=> (rdata_o == $past(ptr0_q)))
      else $error("pointer zero read wrong");

   a_ptr1_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && sel_ptr1)
      |=> (rdata_o == $past(ptr1_q)))
      else $error("pointer one read wrong");

   a_bank_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == `DMBIA_ADDR_BANK)
      |=> (bank_q == $past(wdata_i)))
      else $error("bank selector write lost");

   a_bank_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && sel_bank)
      |=> (rdata_o == $past(bank_q)))
      else $error("bank selector read wrong");

   a_bank_clear: assert property (@(posedge sys_clk_i)
      (rst_i && !wdt_pd_rst_i && !bank_keep_q)
      |=> (bank_q == `DMBIA_RST_BANK))
      else $error("reset left bank selector set");

   a_bank_keep: assert property (@(posedge sys_clk_i)
      (rst_i && wdt_pd_rst_i)
      |=> $stable(bank_q))
      else $error("watchdog power-down reset changed bank");

   a_port1_route: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (addr_i == `DMBIA_ADDR_IND1)
      |-> (eff_addr == ptr1_q && eff_bank == bank_q))
      else $error("port one not routed through pointer and bank");

   a_port_no_store: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      indirect
      |-> (null_acc || eff_addr != addr_i))
      else $error("port access aimed at port storage");

   a_direct_addr: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !indirect
      |-> (eff_addr == addr_i))
      else $error("direct access address changed");

   a_direct_ram: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && !indirect && !sfr)
      |-> ram_we)
      else $error("direct write to general memory dropped");

   a_ind1_bank2: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == `DMBIA_ADDR_IND1 && !sfr && bank_q == 8'h02)
      |-> ram_we)
      else $error("port one write to bank 2 dropped");

   a_bank_range: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (addr_i == `DMBIA_ADDR_IND1 && !sfr && bank_q >= 8'(`DMBIA_NUM_BANKS))
      |-> !ram_we)
      else $error("write to missing bank stored");

   a_bank1_low: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (addr_i == `DMBIA_ADDR_IND1 && bank_q == 8'h01 && ptr1_q < `DMBIA_GP_START)
      |-> (sfr && !absent))
      else $error("bank 1 low address missed special area");

   a_bank1_high: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (addr_i == `DMBIA_ADDR_IND1 && bank_q == 8'h01 && ptr1_q > `DMBIA_BANK1_LAST)
      |-> absent)
      else $error("bank 1 high address not absent");

   a_absent_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && absent)
      |=> (rdata_o == 8'h00))
      else $error("absent location read not zero");

   a_absent_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      absent
      |-> !ram_we)
      else $error("absent location written");

   a_null_ram: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      null_acc
      |-> !ram_we)
      else $error("port aimed at port wrote memory");

   a_null_periph_rd: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      null_acc
      |-> !periph_rd_o)
      else $error("port aimed at port read a peripheral");

   a_sfr_no_ram: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      sfr
      |-> !ram_we)
      else $error("special area write reached memory");

   a_periph_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && sfr && periph_hit_i && !null_acc && !sel_local)
      |=> (rdata_o == $past(periph_rdata_i)))
      else $error("peripheral read data lost");

   a_periph_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && sfr && !null_acc && !sel_local)
      |-> periph_wr_o)
      else $error("peripheral write not forwarded");

   a_acc_hold: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !(acc_load_i || (wr_ok && sel_acc))
      |=> $stable(acc_q))
      else $error("accumulator changed without load");

   a_acc_mem: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (acc_load_i && acc_src_i == 2'b10)
      |=> (acc_q == $past(rd_d)))
      else $error("accumulator missed memory data");

   a_acc_read: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (rd_i && sel_acc)
      |=> (rdata_o == $past(acc_q)))
      else $error("accumulator read wrong");

   a_acc_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (wr_i && addr_i == `DMBIA_ADDR_ACC && !acc_load_i)
      |=> (acc_q == $past(wdata_i)))
      else $error("accumulator write lost");
endmodule : dmbia_top

// >>> dmbia_defines.svh
// Purpose: Constants for the data memory bank and indirect addressing block
// Assumes: 8-bit data, 8-bit addresses within a bank, up to 13 banks
// Notes: Shared by the top, address map and RAM design files
`ifndef DMBIA_DEFINES_SVH
`define DMBIA_DEFINES_SVH
`define DMBIA_ADDR_IND0 8'h00
`define DMBIA_ADDR_PTR0 8'h01
`define DMBIA_ADDR_IND1 8'h02
`define DMBIA_ADDR_PTR1 8'h03
`define DMBIA_ADDR_BANK 8'h04
`define DMBIA_ADDR_ACC 8'h05
`define DMBIA_SFR_LAST 8'h3f
`define DMBIA_GP_START 8'h40
`define DMBIA_BANK1_LAST 8'hbf
`define DMBIA_NUM_BANKS 13
`define DMBIA_RST_BANK 8'h00
`define DMBIA_RST_REG 8'h00
`define DMBIA_RAM_WORDS 3328
`endif

// >>> dmbia_pkg.sv
// Purpose: Types for the data memory bank block
// Assumes: Constants come from the defines header
// Notes: Holds types only
package dmbia_pkg;
   typedef logic [7:0] dmbia_byte_t;
   typedef enum logic [1:0] {
      DMBIA_SRC_BUS = 2'b00,
      DMBIA_SRC_ALU = 2'b01,
      DMBIA_SRC_MEM = 2'b10
   } dmbia_accsrc_e;
endpackage : dmbia_pkg

// >>> dmbia_addr_map.sv
// Purpose: Resolves a data memory access to a bank and address
// Assumes: Indirect accesses name the port by its own address
// Notes: Purely combinational
`include "dmbia_defines.svh"
module dmbia_addr_map (
   input wire logic [7:0] addr_i, // Instruction operand address
   input wire logic [7:0] ptr0_i, // Pointer zero contents
   input wire logic [7:0] ptr1_i, // Pointer one contents
   input wire logic [7:0] bank_i, // Bank selector contents
   output logic [7:0] eff_addr_o, // Resolved address in bank
   output logic [7:0] eff_bank_o, // Resolved bank
   output logic indirect_o, // Access went through a port
   output logic null_o, // Pointer aims at a port
   output logic sfr_o, // Resolved address is in special area
   output logic absent_o // Location not implemented
);
   function automatic logic is_port(input logic [7:0] a);
      is_port = (a == `DMBIA_ADDR_IND0) || (a == `DMBIA_ADDR_IND1);
   endfunction : is_port

   always_comb begin
      eff_addr_o = addr_i;
      eff_bank_o = `DMBIA_RST_BANK;
      indirect_o = 1'b0;
      if (addr_i == `DMBIA_ADDR_IND0) begin
         eff_addr_o = ptr0_i;
         indirect_o = 1'b1;
      end else if (addr_i == `DMBIA_ADDR_IND1) begin
         eff_addr_o = ptr1_i;
         eff_bank_o = bank_i;
         indirect_o = 1'b1;
      end
      sfr_o = (eff_addr_o <= `DMBIA_SFR_LAST);
      null_o = indirect_o && is_port(eff_addr_o);
      absent_o = (!sfr_o && (eff_bank_o >= 8'(`DMBIA_NUM_BANKS)))
         || (!sfr_o && (eff_bank_o == 8'h01) && (eff_addr_o > `DMBIA_BANK1_LAST));
   end
endmodule : dmbia_addr_map

// >>> dmbia_ram.sv
// Purpose: General purpose storage for all banks
// Assumes: 256 locations reserved per bank, only 40H and up used
// Notes: Read is combinational from the array
`include "dmbia_defines.svh"
module dmbia_ram (
   input wire logic sys_clk_i, // System clock
   input wire logic we_i, // Write strobe
   input wire logic [11:0] addr_i, // Bank and address
   input wire logic [7:0] wdata_i, // Write data
   output logic [7:0] rdata_o // Read data
);
   logic [7:0] mem_q [0:`DMBIA_RAM_WORDS-1];

   always_ff @(posedge sys_clk_i) begin
      if (we_i) begin
         mem_q[addr_i] <= wdata_i;
      end
   end

   assign rdata_o = mem_q[addr_i];
endmodule : dmbia_ram

// >>> dmbia_core_model.sv
// Purpose: Far-side model of the core: ALU result and one peripheral register
// Assumes: ALU increments the accumulator; one peripheral answers at 0ah
// Notes: Unclaimed read data toggles every cycle so it is never a clean 00h
module dmbia_core_model (
   input wire logic sys_clk_i, // System clock
   input wire logic [7:0] acc_i, // Accumulator
   input wire logic [7:0] periph_addr_i, // Resolved special address
   output logic [7:0] alu_result_o, // ALU result
   output logic [7:0] periph_rdata_o, // Peripheral read data
   output logic periph_hit_o // Peripheral claims address
);
   logic [7:0] noise_q = 8'h5a;
   always_ff @(posedge sys_clk_i) begin
      noise_q <= ~noise_q;
   end
   assign alu_result_o = acc_i + 8'h01;
   assign periph_hit_o = (periph_addr_i == 8'h0a);
   assign periph_rdata_o = periph_hit_o ? 8'hc3 : noise_q;
endmodule : dmbia_core_model

// >>> data_memory_bank_indirect_addressing_test.sv
// Purpose: Self-checking bench for the data memory bank block
// Assumes: Inputs change at falling edges; read data checked a cycle later
// Notes: Core model supplies ALU and peripheral responses
module data_memory_bank_indirect_addressing_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk_i = 1'b0, rst_i = 1'b1, wdt_pd_rst_i = 1'b0;
   logic [7:0] addr_i = 8'h00, wdata_i = 8'h00;
   logic rd_i = 1'b0, wr_i = 1'b0, acc_load_i = 1'b0;
   logic [1:0] acc_src_i = 2'b00;
   logic [7:0] alu_result_i, periph_rdata_i, rdata_o, periph_addr_o, acc_o, ptr0_o, ptr1_o, bank_o;
   logic periph_hit_i, periph_wr_o, periph_rd_o;
   int miscompares = 0;
   int samples_checked = 0;
   always #25 sys_clk_i = ~sys_clk_i;
   dmbia_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .wdt_pd_rst_i(wdt_pd_rst_i), .addr_i(addr_i),
      .rd_i(rd_i), .wr_i(wr_i), .wdata_i(wdata_i), .acc_load_i(acc_load_i), .acc_src_i(acc_src_i),
      .alu_result_i(alu_result_i), .periph_rdata_i(periph_rdata_i), .periph_hit_i(periph_hit_i),
      .rdata_o(rdata_o), .periph_wr_o(periph_wr_o), .periph_rd_o(periph_rd_o), .periph_addr_o(periph_addr_o),
      .acc_o(acc_o), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o), .bank_o(bank_o));
   dmbia_core_model core (.sys_clk_i(sys_clk_i), .acc_i(acc_o), .periph_addr_i(periph_addr_o),
      .alu_result_o(alu_result_i), .periph_rdata_o(periph_rdata_i), .periph_hit_o(periph_hit_i));
   task automatic wrap_up;
      $display("Checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : wrap_up
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      @(negedge sys_clk_i);
      wr_i = 1'b0;
      @(negedge sys_clk_i);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      addr_i = a;
      rd_i = 1'b1;
      @(negedge sys_clk_i);
      rd_i = 1'b0;
      chk($sformatf("read %h", a), e, rdata_o);
      @(negedge sys_clk_i);
   endtask : rd
   task automatic acc_load(input logic [1:0] s, input logic [7:0] a);
      addr_i = a;
      acc_src_i = s;
      rd_i = (s == dmbia_pkg::DMBIA_SRC_MEM);
      acc_load_i = 1'b1;
      @(negedge sys_clk_i);
      acc_load_i = 1'b0;
      rd_i = 1'b0;
      @(negedge sys_clk_i);
   endtask : acc_load
   task automatic fwd(input logic [7:0] a, input logic w, input logic e);
      addr_i = a;
      wdata_i = 8'h00;
      wr_i = w;
      rd_i = !w;
      #10;
      chk(w ? "periph wr" : "periph rd", {7'h00, e}, {7'h00, w ? periph_wr_o : periph_rd_o});
      @(negedge sys_clk_i);
      wr_i = 1'b0;
      rd_i = 1'b0;
      @(negedge sys_clk_i);
   endtask : fwd
   task automatic reset_pulse(input logic w);
      rst_i = 1'b1;
      wdt_pd_rst_i = w;
      repeat (3) @(negedge sys_clk_i);
      rst_i = 1'b0;
      wdt_pd_rst_i = 1'b0;
      @(negedge sys_clk_i);
   endtask : reset_pulse
   initial begin
      repeat (5000) @(posedge sys_clk_i);
      miscompares++;
      wrap_up();
   end
   initial begin
      repeat (20) @(negedge sys_clk_i);
      rst_i = 1'b0;
      @(negedge sys_clk_i);
      chk("bank", 8'h00, bank_o);
      wr(8'h01, 8'h45);
      rd(8'h01, 8'h45);
      chk("ptr0", 8'h45, ptr0_o);
      wr(8'h00, 8'h11);
      rd(8'h45, 8'h11);
      wr(8'h04, 8'h02);
      wr(8'h03, 8'h45);
      wr(8'h02, 8'h22);
      rd(8'h02, 8'h22);
      rd(8'h00, 8'h11);
      rd(8'h45, 8'h11);
      wr(8'h03, 8'h04);
      rd(8'h02, 8'h02);
      rd(8'h3e, 8'h00);
      rd(8'h3f, 8'h00);
      rd(8'h0a, 8'hc3);
      fwd(8'h0a, 1'b1, 1'b1);
      fwd(8'h0a, 1'b0, 1'b1);
      wr(8'h01, 8'h02);
      wr(8'h00, 8'h77);
      fwd(8'h00, 1'b1, 1'b0);
      fwd(8'h00, 1'b0, 1'b0);
      rd(8'h00, 8'h00);
      rd(8'h03, 8'h04);
      wr(8'h04, 8'h01);
      wr(8'h03, 8'hbf);
      wr(8'h02, 8'h66);
      rd(8'h02, 8'h66);
      wr(8'h03, 8'hc0);
      rd(8'h02, 8'h00);
      wr(8'h03, 8'h03);
      rd(8'h02, 8'h03);
      wr(8'h03, 8'h50);
      for (int b = 0; b < 13; b++) begin
         wr(8'h04, 8'(b));
         wr(8'h02, 8'(b + 8'h80));
      end
      for (int b = 0; b < 13; b++) begin
         wr(8'h04, 8'(b));
         rd(8'h02, 8'(b + 8'h80));
      end
      wr(8'h04, 8'h0d);
      rd(8'h02, 8'h00);
      acc_load(dmbia_pkg::DMBIA_SRC_ALU, 8'h00);
      chk("acc alu", 8'h01, acc_o);
      acc_load(dmbia_pkg::DMBIA_SRC_MEM, 8'h45);
      chk("acc mem", 8'h11, acc_o);
      wr(8'h05, 8'h3c);
      rd(8'h05, 8'h3c);
      wr(8'h04, 8'h05);
      reset_pulse(1'b1);
      chk("bank wdt", 8'h05, bank_o);
      reset_pulse(1'b0);
      chk("bank rst", 8'h00, bank_o);
      wrap_up();
   end
endmodule : data_memory_bank_indirect_addressing_test
